// file: logic/tsb_bridge.sv
`timescale 1ns/1ps
`include "tsb_defs.svh"

module tsb_bridge
    import tsb_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Controller bus, active low
    input wire logic controller_set_strobe_n,
    input wire logic reverse_command_n,
    input wire logic [2:0] unit_select_code_n,
    input wire logic [1:0] density_code_n,
    input wire logic halt_command_n,
    input wire logic motion_delay_request_n,
    input wire logic transfer_hold_n,
    input wire logic [8:0] write_char_lines_n,
    input wire logic record_strobe_n,
    input wire logic check_char_ready_n,
    output logic [8:0] read_char_lines_n,
    output logic read_char_strobe_n,
    output logic high_density_write_clock_n,
    output logic mid_density_write_clock_n,
    output logic seven_track_flag_n,
    output logic settling_indication_n,
    output logic unit_ready_indication_n,
    // Controller shared lines, an input and an output each, one common enable
    input wire logic shared_rewind_status_line_in_n,
    input wire logic shared_lock_offline_line_in_n,
    input wire logic shared_tape_end_line_in_n,
    input wire logic shared_tape_start_line_in_n,
    output logic shared_rewind_status_line_out_n,
    output logic shared_lock_offline_line_out_n,
    output logic shared_tape_end_line_out_n,
    output logic shared_tape_start_line_out_n,
    output logic shared_lines_oe_n,
    // Drive bus outputs, active high
    output logic drive_set_pulse,
    output logic forward_line,
    output logic reverse_line,
    output logic rewind_line,
    output logic write_line,
    output logic [2:0] slave_select,
    output logic [1:0] density_select,
    output logic stop_line,
    output logic motion_delay_enable,
    output logic accelerating,
    output logic [8:0] write_data,
    output logic record_pulse,
    output logic check_char_strobe,
    // Drive bus inputs, active high
    input wire logic medium_online,
    input wire logic drive_clock,
    input wire logic host_clock,
    input wire logic [8:0] read_data,
    input wire logic deskewed_read_strobe,
    input wire logic rewind_status,
    input wire logic write_lock_status,
    input wire logic end_of_tape_status,
    input wire logic beginning_of_tape_status,
    input wire logic seven_track,
    input wire logic drive_settling,
    input wire logic drive_unit_ready
);

    // ------------------------------------------------------------
    // Constants and helpers
    // ------------------------------------------------------------
    localparam int PULSE_CYC = `TSB_PULSE_CYCLES;
    localparam int SETTLE_CYC = `TSB_SETTLE_CYCLES;

    // Retriggerable one-shot count
    function automatic logic [7:0] one_shot(input logic trig,
                                            input logic [7:0] cnt);
        if (trig)
            return 8'(PULSE_CYC);
        else if (cnt != 8'h00)
            return cnt - 8'h01;
        else
            return 8'h00;
    endfunction

    // Free divider step: toggle after half counts of input edges
    function automatic logic [5:0] div_step(input logic en,
                                            input logic edge_in,
                                            input logic [4:0] cnt,
                                            input logic out,
                                            input logic [4:0] half);
        if (!en)
            return 6'h00;
        else if (edge_in && (cnt == half - 5'h01))
            return {5'h00, ~out};
        else if (edge_in)
            return {cnt + 5'h01, out};
        else
            return {cnt, out};
    endfunction

    tsb_state_t s;
    tsb_state_t next_s;
    logic set_on;
    logic set_rise;
    logic den556;
    logic wr_ok;
    logic rd_ok;
    logic [5:0] d4;
    logic [5:0] d46;

    assign set_on = ~controller_set_strobe_n;
    assign set_rise = set_on & ~s.set_d;
    assign den556 = ~density_code_n[0] & density_code_n[1];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        d4 = 6'h00;
        d46 = 6'h00;
        wr_ok = 1'b0;
        rd_ok = 1'b0;
        // Command latch on the leading edge of the set strobe
        next_s.set_d = set_on;
        if (set_rise)
        begin
            next_s.cmd_fwd = ~shared_tape_start_line_in_n;
            next_s.cmd_rew = ~shared_tape_end_line_in_n;
            next_s.cmd_off = ~shared_lock_offline_line_in_n;
            next_s.cmd_wre = ~shared_rewind_status_line_in_n;
            next_s.cmd_rev = ~reverse_command_n;
            next_s.lrc_strb = 1'b0;
        end
        next_s.set_cnt = one_shot(set_rise, s.set_cnt);
        // Control lines converted to drive polarity
        next_s.sel = ~unit_select_code_n;
        next_s.den = ~density_code_n;
        next_s.stop = ~halt_command_n;
        next_s.emd = ~motion_delay_request_n;
        // Settling delayed before it masks rewind status
        if (drive_settling == s.sd_dly)
            next_s.sd_cnt = 4'h0;
        else if (s.sd_cnt == 4'(SETTLE_CYC - 1))
        begin
            next_s.sd_dly = drive_settling;
            next_s.sd_cnt = 4'h0;
        end
        else
            next_s.sd_cnt = s.sd_cnt + 4'h1;
        // Status returned on the shared lines
        next_s.stat_drv = ~set_on & medium_online;
        next_s.stat = {rewind_status & ~s.sd_dly,
                       write_lock_status, end_of_tape_status,
                       beginning_of_tape_status} & {4{medium_online}};
        next_s.misc = {seven_track, drive_settling, drive_unit_ready}
                      & {3{medium_online}};
        // Write path: latch character and fire record pulse
        next_s.rec_d = ~record_strobe_n & medium_online;
        next_s.ccr_d = ~check_char_ready_n & medium_online;
        if (next_s.rec_d && !s.rec_d)
            next_s.wdata = ~write_char_lines_n;
        next_s.rec_cnt = one_shot(next_s.rec_d & ~s.rec_d, s.rec_cnt);
        if (next_s.ccr_d && !s.ccr_d)
        begin
            next_s.lrc_strb = 1'b1;
            next_s.wdata = 9'h000;
        end
        // Read path: latch character and fire read strobe
        next_s.rsdo_d = deskewed_read_strobe & medium_online;
        if (next_s.rsdo_d && !s.rsdo_d)
            next_s.rdata = read_data;
        else if (s.skew_cnt == 8'h01)
            next_s.rdata = 9'h000;
        next_s.skew_cnt = one_shot(next_s.rsdo_d & ~s.rsdo_d,
                                   s.skew_cnt);
        if (s.emd && medium_online)
            next_s.rd_out = {s.delay_code, s.rdata[0]};
        else
            next_s.rd_out = s.rdata;
        // Write clocks from the drive and host clocks
        next_s.dclk_d = drive_clock;
        next_s.hclk_d = host_clock;
        d4 = div_step(medium_online, drive_clock & ~s.dclk_d,
                      {3'h0, s.div4_cnt}, s.div4_out,
                      5'(`TSB_DIV4_HALF));
        next_s.div4_cnt = d4[2:1];
        next_s.div4_out = d4[0];
        d46 = div_step(medium_online, host_clock & ~s.hclk_d,
                       s.div46_cnt, s.div46_out, 5'(`TSB_DIV46_HALF));
        next_s.div46_cnt = d46[5:1];
        next_s.div46_out = d46[0];
        next_s.mid_out = s.div46_out & den556 & medium_online;
        // AXI write channel: address and data in either order
        if (s_axi_awvalid && s_axi_awready)
        begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = 8'(s_axi_awaddr);
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
            next_s.w_got = 1'b1;
            next_s.w_data = s_axi_wdata;
            next_s.w_strb = s_axi_wstrb;
        end
        if (s.aw_got && s.w_got && !s.bvalid)
        begin
            wr_ok = (s.aw_addr == `TSB_REG_DELAY);
            if (wr_ok && s.w_strb[0])
                next_s.delay_code = s.w_data[7:0];
            next_s.bresp = (wr_ok || s.aw_addr == `TSB_REG_STATUS)
                           ? `TSB_RESP_OKAY : `TSB_RESP_SLVERR;
            next_s.bvalid = 1'b1;
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        // AXI read channel
        if (s_axi_arvalid && s_axi_arready)
        begin
            rd_ok = 1'b1;
            next_s.rresp = `TSB_RESP_OKAY;
            case (8'(s_axi_araddr))
                `TSB_REG_DELAY: next_s.rdata_bus = {24'h0, s.delay_code};
                `TSB_REG_STATUS: next_s.rdata_bus = {24'h0, s.lrc_strb,
                    s.sd_dly, medium_online, s.cmd_wre, s.cmd_off,
                    s.cmd_rew, s.cmd_rev, s.cmd_fwd};
                default:
                begin
                    next_s.rdata_bus = 32'h0;
                    next_s.rresp = `TSB_RESP_SLVERR;
                end
            endcase
            next_s.rvalid = rd_ok;
        end
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;
    end

    // State register
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
            s <= '0;
        else
            s <= next_s;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus handshakes
    assign s_axi_awready = ~s.aw_got & ~s.bvalid;
    assign s_axi_wready = ~s.w_got & ~s.bvalid;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = ~s.rvalid;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata_bus;
    assign s_axi_rresp = s.rresp;

    // Drive side
    assign drive_set_pulse = (s.set_cnt != 8'h00);
    assign forward_line = s.cmd_fwd;
    assign rewind_line = s.cmd_rew;
    assign write_line = s.cmd_off | s.cmd_wre;
    assign reverse_line = s.cmd_rev;
    assign slave_select = s.sel;
    assign density_select = s.den;
    assign stop_line = s.stop;
    assign motion_delay_enable = s.emd;
    assign accelerating = s.stat[3] | s.sd_dly & rewind_status;
    assign write_data = s.wdata;
    assign record_pulse = (s.rec_cnt != 8'h00);
    assign check_char_strobe = s.lrc_strb;

    // Controller side, inverted
    // Let go at once when set comes, so latched commands are not status
    assign shared_lines_oe_n = ~s.stat_drv | set_on;
    assign shared_rewind_status_line_out_n = ~s.stat[3];
    assign shared_lock_offline_line_out_n = ~s.stat[2];
    assign shared_tape_end_line_out_n = ~s.stat[1];
    assign shared_tape_start_line_out_n = ~s.stat[0];
    assign seven_track_flag_n = ~s.misc[2];
    assign settling_indication_n = ~s.misc[1];
    assign unit_ready_indication_n = ~s.misc[0];
    assign read_char_lines_n = ~s.rd_out;
    assign read_char_strobe_n = ~(s.skew_cnt != 8'h00);
    assign high_density_write_clock_n = ~s.div4_out;
    assign mid_density_write_clock_n = ~s.mid_out;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    a_set_pulse_load: assert property (
        set_rise |=> drive_set_pulse [*8])
        else $error("set pulse too short");
    a_cmd_latch: assert property (
        set_rise |=> forward_line == !$past(shared_tape_start_line_in_n))
        else $error("forward command not latched");
    a_rev_latch: assert property (
        set_rise |=> reverse_line == !$past(reverse_command_n))
        else $error("reverse command not latched");
    a_status_float: assert property (
        set_on |=> shared_lines_oe_n)
        else $error("shared lines driven during set strobe");
    a_status_gate: assert property (
        (!set_on && medium_online) ##1 !set_on |-> !shared_lines_oe_n)
        else $error("status not gated onto shared lines");
    a_rws_mask: assert property (
        s.sd_dly |=> shared_rewind_status_line_out_n)
        else $error("rewind status not masked by settling");
    a_settle_hold: assert property (
        ($rose(drive_settling) && !s.sd_dly) |-> !s.sd_dly [*8])
        else $error("settling delay too short");
    a_read_strobe: assert property (
        (next_s.rsdo_d && !s.rsdo_d) |=> !read_char_strobe_n [*8])
        else $error("read strobe pulse missing");
    a_clock_gate: assert property (
        !medium_online |=> ##1 mid_density_write_clock_n)
        else $error("mid density clock runs offline");
    a_delay_code: assert property (
        (s.emd && medium_online) |=> read_char_lines_n[8:1]
            == ~$past(s.delay_code))
        else $error("delay code not on read lines");

    c_set_cycle: cover property (set_rise ##[1:40] !drive_set_pulse);
    c_check_char: cover property ($rose(check_char_strobe)
                                  ##[1:100] record_pulse);
    c_read_char: cover property ($fell(read_char_strobe_n));
    c_mid_clock: cover property ($fell(mid_density_write_clock_n));

endmodule

// file: shared/tsb_defs.svh
`ifndef TSB_DEFS_SVH
`define TSB_DEFS_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TSB_CLK_NS 8
`define TSB_SETTLE_NS 100
`define TSB_SETTLE_CYCLES ((`TSB_SETTLE_NS + `TSB_CLK_NS - 1) / `TSB_CLK_NS)
`define TSB_PULSE_NS 200
`define TSB_PULSE_CYCLES ((`TSB_PULSE_NS + `TSB_CLK_NS - 1) / `TSB_CLK_NS)
`define TSB_DIV4_HALF 2
`define TSB_DIV46_HALF 23

// ----------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------
`define TSB_REG_DELAY 8'h00
`define TSB_REG_STATUS 8'h04
`define TSB_RESP_OKAY 2'h0
`define TSB_RESP_SLVERR 2'h2
`define TSB_DELAY_W 8

`endif

// file: shared/tsb_pkg.sv
package tsb_pkg;

    // All state of the bridge, registered as one word
    typedef struct packed {
        logic set_d;
        logic cmd_fwd;
        logic cmd_rew;
        logic cmd_off;
        logic cmd_wre;
        logic cmd_rev;
        logic [7:0] set_cnt;
        logic [7:0] rec_cnt;
        logic [7:0] skew_cnt;
        logic rec_d;
        logic ccr_d;
        logic rsdo_d;
        logic dclk_d;
        logic hclk_d;
        logic [1:0] div4_cnt;
        logic div4_out;
        logic [4:0] div46_cnt;
        logic div46_out;
        logic mid_out;
        logic [8:0] wdata;
        logic [8:0] rdata;
        logic [8:0] rd_out;
        logic lrc_strb;
        logic sd_dly;
        logic [3:0] sd_cnt;
        logic stat_drv;
        logic [3:0] stat;
        logic [2:0] misc;
        logic [2:0] sel;
        logic [1:0] den;
        logic stop;
        logic emd;
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata_bus;
        logic [7:0] delay_code;
    } tsb_state_t;

endpackage

// file: test/test_tsb_bridge.sv
`timescale 1ns/1ps
`include "tsb_defs.svh"
// ----------------------------------------
// Self-checking bench for the tape bridge
// ----------------------------------------
module test_tsb_bridge;
    localparam int PW = `TSB_PULSE_CYCLES;
    localparam int SD = `TSB_SETTLE_CYCLES;
    logic core_clk, nrst;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic controller_set_strobe_n, reverse_command_n, halt_command_n;
    logic motion_delay_request_n, transfer_hold_n;
    logic record_strobe_n, check_char_ready_n;
    logic [2:0] unit_select_code_n, slave_select;
    logic [1:0] density_code_n, density_select;
    logic [8:0] write_char_lines_n, read_char_lines_n, write_data, read_data;
    logic read_char_strobe_n, high_density_write_clock_n;
    logic mid_density_write_clock_n, seven_track_flag_n;
    logic settling_indication_n, unit_ready_indication_n;
    logic shared_rewind_status_line_in_n, shared_lock_offline_line_in_n;
    logic shared_tape_end_line_in_n, shared_tape_start_line_in_n;
    logic shared_rewind_status_line_out_n, shared_lock_offline_line_out_n;
    logic shared_tape_end_line_out_n, shared_tape_start_line_out_n;
    logic shared_lines_oe_n, drive_set_pulse, forward_line, reverse_line;
    logic rewind_line, write_line, stop_line, motion_delay_enable;
    logic accelerating, record_pulse, check_char_strobe;
    logic medium_online, drive_clock, host_clock, deskewed_read_strobe;
    logic rewind_status, write_lock_status, end_of_tape_status;
    logic beginning_of_tape_status, seven_track, drive_settling;
    logic drive_unit_ready, ctl_en;
    logic [3:0] ctl_val, sh_out, sh_wire;
    int failures, cmp_count, n, hd, md, dr, hr;
    // Command table, each entry {wre, off, rew, fwd, rev}
    logic [4:0] tbl [5] = '{5'h02, 5'h05, 5'h08, 5'h10, 5'h0c};

    // Shared lines: device when enabled, else controller, else pull-up
    assign sh_out = {shared_rewind_status_line_out_n,
        shared_lock_offline_line_out_n, shared_tape_end_line_out_n,
        shared_tape_start_line_out_n};
    assign sh_wire = !shared_lines_oe_n ? sh_out : ctl_en ? ctl_val : 4'hf;
    assign {shared_rewind_status_line_in_n, shared_lock_offline_line_in_n,
        shared_tape_end_line_in_n, shared_tape_start_line_in_n} = sh_wire;

    tsb_bridge dut (.*);
    tsb_drive_model drv (.*);

    // 125 MHz clock
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
    begin
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    end
    endtask

    task wrap_up;
    begin
        $display("Counts: %0d compared, %0d mismatched", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask

    // Bus write: address and data offered together, each released when taken
    task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        n = 0;
        do
        begin
            cyc(1);
            n++;
            if (s_axi_awvalid && s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end
        while (!s_axi_bvalid && n < 100);
        s_axi_bready <= 1'b0;
        chk("bresp", r, s_axi_bresp);
        cyc(1);
    end
    endtask

    task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    begin
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        n = 0;
        do
        begin
            cyc(1);
            n++;
            if (s_axi_arvalid && s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end
        while (!s_axi_rvalid && n < 100);
        s_axi_rready <= 1'b0;
        chk("rdata", d, s_axi_rdata);
        chk("rresp", r, s_axi_rresp);
        cyc(1);
    end
    endtask

    // Controller set with commands on the shared lines, then status back
    task set_cmd(input logic [4:0] c);
    begin
        {drv.rewind_status, drv.write_lock_status} <= c[4:3];
        {drv.end_of_tape_status, drv.beginning_of_tape_status} <= c[2:1];
        {ctl_en, ctl_val} <= {1'b1, ~c[4:1]};
        reverse_command_n <= ~c[0];
        controller_set_strobe_n <= 1'b0;
        halt_command_n <= 1'b1;
        n = 0;
        for (int i = 0; i < 40; i++)
        begin
            cyc(1);
            n += int'(drive_set_pulse === 1'b1);
            if (i == 1)
                chk("oe during set", 1, shared_lines_oe_n);
            if (i == 2)
                {controller_set_strobe_n, ctl_en} <= 2'b10;
        end
        chk("set pulse", PW, n);
        chk("latched", {c[4] | c[3], c[2:0]},
            {write_line, rewind_line, forward_line, reverse_line});
        chk("status lines", {~c[4:1]}, sh_wire);
    end
    endtask

    // Toggles of both write clocks against rising edges of their sources
    task count_clk;
        logic [3:0] p;
    begin
        {hd, md, dr, hr} = {32'h0, 32'h0, 32'h0, 32'h0};
        p = {high_density_write_clock_n, mid_density_write_clock_n,
            drive_clock, host_clock};
        repeat (480)
        begin
            cyc(1);
            hd += int'(high_density_write_clock_n != p[3]);
            md += int'(mid_density_write_clock_n != p[2]);
            dr += int'(drive_clock & !p[1]);
            hr += int'(host_clock & !p[0]);
            p = {high_density_write_clock_n, mid_density_write_clock_n,
                drive_clock, host_clock};
        end
    end
    endtask

    // Watchdog against a hang
    initial
    begin
        cyc(12000);
        failures++;
        $display("unexpected hang: watchdog expired");
        wrap_up;
    end

    // Main sequence
    initial
    begin
        nrst = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, ctl_en} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hf;
        {controller_set_strobe_n, reverse_command_n, halt_command_n} = 3'h7;
        {motion_delay_request_n, transfer_hold_n} = 2'h3;
        {record_strobe_n, check_char_ready_n, ctl_val} = 6'h3f;
        {unit_select_code_n, density_code_n} = 5'h1f;
        write_char_lines_n = 9'h1ff;
        {failures, cmp_count} = {32'h0, 32'h0};
        cyc(4);
        nrst <= 1'b1;
        cyc(1);
        chk("idle outputs", 3'h6, {shared_lines_oe_n, read_char_strobe_n,
            drive_set_pulse});
        axi_rd(`TSB_REG_DELAY, 32'h0, `TSB_RESP_OKAY);
        axi_rd(`TSB_REG_STATUS, 32'h0, `TSB_RESP_OKAY);
        axi_rd(8'h08, 32'h0, `TSB_RESP_SLVERR);
        axi_wr(8'h08, 32'h1, `TSB_RESP_SLVERR);
        axi_wr(`TSB_REG_STATUS, 32'hff, `TSB_RESP_OKAY);
        axi_wr(`TSB_REG_DELAY, 32'ha5, `TSB_RESP_OKAY);
        axi_rd(`TSB_REG_DELAY, 32'ha5, `TSB_RESP_OKAY);
        $display("register test done");
        unit_select_code_n <= 3'h5;
        density_code_n <= 2'h2;
        halt_command_n <= 1'b0;
        cyc(3);
        chk("pass lines", 6'h13, {slave_select, density_select,
            stop_line});
        $display("control test done");
        drv.medium_online <= 1'b1;
        cyc(20);
        for (int i = 0; i < 5; i++)
            set_cmd(tbl[i]);
        $display("command test done");
        {drv.rewind_status, drv.drive_settling, drv.drive_unit_ready} <= 3'h4;
        cyc(SD + 4);
        chk("rewind shown", 2'h1, {sh_wire[3], accelerating});
        drv.drive_settling <= 1'b1;
        cyc(SD + 4);
        chk("rewind masked", 2'h2, {sh_wire[3],
            settling_indication_n});
        drv.drive_settling <= 1'b0;
        n = 0;
        repeat (SD + 8)
        begin
            cyc(1);
            n += int'(sh_wire[3] === 1'b1);
        end
        chk("mask delay", 1, n >= SD && n <= SD + 3);
        drv.drive_settling <= 1'b1;
        cyc(SD + 4);
        // Settling ends a cycle before rewind status: the race to hide
        {drv.drive_settling, drv.drive_unit_ready} <= 2'h1;
        n = 0;
        repeat (SD + 8)
        begin
            cyc(1);
            drv.rewind_status <= 1'b0;
            n += int'(sh_wire[3] !== 1'b1);
        end
        chk("rewind glitch", 0, n);
        chk("ready shown", 0, unit_ready_indication_n);
        $display("settling test done");
        write_char_lines_n <= ~9'h15a;
        record_strobe_n <= 1'b0;
        n = 0;
        for (int i = 0; i < 40; i++)
        begin
            cyc(1);
            n += int'(record_pulse === 1'b1);
            if (i == 2)
                record_strobe_n <= 1'b1;
        end
        chk("record pulse", PW, n);
        chk("write data", 9'h15a, write_data);
        check_char_ready_n <= 1'b0;
        cyc(3);
        chk("check char", 10'h200, {check_char_strobe, write_data});
        {check_char_ready_n, record_strobe_n} <= 2'h2;
        cyc(3);
        chk("strobe before rec", 2'h3, {check_char_strobe, record_pulse});
        record_strobe_n <= 1'b1;
        cyc(30);
        $display("write test done");
        drv.send_char(9'h0c3);
        cyc(1);
        chk("read char", 10'h0c3, {read_char_strobe_n,
            ~read_char_lines_n});
        cyc(30);
        chk("one read strobe", 1, read_char_strobe_n);
        {motion_delay_request_n, transfer_hold_n} <= 2'h0;
        cyc(4);
        chk("delay code", 9'h1a5, {motion_delay_enable,
            ~read_char_lines_n[8:1]});
        motion_delay_request_n <= 1'b1;
        cyc(2);
        transfer_hold_n <= 1'b1;
        $display("read test done");
        {drv.seven_track, drv.drive_settling} <= 2'h3;
        count_clk;
        chk("status online", 3'h0, {seven_track_flag_n,
            settling_indication_n, unit_ready_indication_n});
        chk("fast clock", 1, hd >= dr / 2 - 1 && hd <= dr / 2 + 1);
        chk("mid clock", 1, md > 0 && md >= hr / 23 - 1
            && md <= hr / 23 + 1);
        density_code_n <= 2'h1;
        cyc(4);
        count_clk;
        chk("mid idle", 1, md == 0 && mid_density_write_clock_n);
        drv.medium_online <= 1'b0;
        cyc(4);
        count_clk;
        chk("offline", 5'h1f, {shared_lines_oe_n, seven_track_flag_n,
            settling_indication_n, unit_ready_indication_n,
            hd == 0 && high_density_write_clock_n});
        $display("clock test done");
        wrap_up;
    end
endmodule

// file: test/tsb_drive_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Drive-side model of the positive bus
// ----------------------------------------
module tsb_drive_model
(
    // Clock
    input wire logic core_clk,
    // Drive bus toward the bridge
    output logic medium_online,
    output logic drive_clock,
    output logic host_clock,
    output logic [8:0] read_data,
    output logic deskewed_read_strobe,
    output logic rewind_status,
    output logic write_lock_status,
    output logic end_of_tape_status,
    output logic beginning_of_tape_status,
    output logic seven_track,
    output logic drive_settling,
    output logic drive_unit_ready
);
    logic [2:0] div = 3'h0;
    // Idle, offline drive at time zero
    initial
    begin
        {medium_online, drive_clock, host_clock} = 3'h0;
        {deskewed_read_strobe, rewind_status, write_lock_status} = 3'h0;
        {end_of_tape_status, beginning_of_tape_status} = 2'h0;
        {seven_track, drive_settling, drive_unit_ready} = 3'h0;
        read_data = 9'h0aa;
    end
    // Scaled clocks, running only while the medium is online
    always @(posedge core_clk)
    begin
        div <= div + 3'h1;
        host_clock <= medium_online & div[0];
        drive_clock <= medium_online & div[2];
    end
    // One read character; lines show the inverse once released
    task send_char(input logic [8:0] d);
    begin
        @(posedge core_clk);
        read_data <= d;
        deskewed_read_strobe <= 1'b1;
        repeat (2) @(posedge core_clk);
        deskewed_read_strobe <= 1'b0;
        @(posedge core_clk);
        read_data <= ~d;
    end
    endtask
endmodule
